// >>> hdl/fec_pkg.sv
// shared constants and carriers for the flash command interpreter
package fec_pkg;
  localparam logic [7:0] OP_ERASE_B0   = 8'hc7;
  localparam logic [7:0] OP_ERASE_B1   = 8'h94;
  localparam logic [7:0] OP_ERASE_B2   = 8'h80;
  localparam logic [7:0] OP_ERASE_B3   = 8'h9a;
  localparam logic [7:0] OP_PROT_B0    = 8'h3d;
  localparam logic [7:0] OP_PROT_B1    = 8'h2a;
  localparam logic [7:0] OP_PROT_B2    = 8'h7f;
  localparam logic [7:0] OP_PROT_EN    = 8'ha9;
  localparam logic [7:0] OP_PROT_DIS   = 8'h9a;
  localparam logic [7:0] OP_RMW        = 8'h58;
  localparam logic [7:0] SECT_PROT_VAL = 8'hff;
  localparam int         NUM_SECT      = 8;
  localparam int         PAGE_BITS     = 10;
  localparam int         CLK_HZ        = 25_000_000;
  localparam int         ERASE_TIME_US = 1000;
  localparam int         PROG_TIME_US  = 100;
  localparam int         ERASE_CYC     = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int         PROG_CYC      = PROG_TIME_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    FEC_OP_ERASE   = 2'h0,
    FEC_OP_RMW     = 2'h1,
    FEC_OP_REWRITE = 2'h2
  } fec_op_t;

  // job handed to the array sequencer
  typedef struct packed {
    fec_op_t              op;
    logic [PAGE_BITS-1:0] page;
    logic [8:0]           start;
    logic [8:0]           count;
  } fec_job_t;

  typedef struct packed {
    logic ready;
    logic prog_error;
    logic prot_enabled;
  } fec_status_t;
endpackage

// >>> hdl/fec_sync.sv
// two-flop synchroniser with edge outputs
`timescale 1ns/10ps
`default_nettype none
module fec_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
      last_reg <= RST_VAL;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign dout = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// >>> hdl/fec_top.sv
// serial command interpreter: chip erase, read-modify-write, software protection
// Function
// - chip erase needs exactly bytes c7 94 80 9a, no address bytes.
// - bytes after the chip erase opcode are discarded until select rises.
// - chip erase starts only on select rising after the final opcode bit.
// - busy is shown for the whole self-timed chip erase.
// - chip erase skips protected or locked sectors.
// - write-protect pin asserted during erase takes effect after erase ends.
// - an erase failure during chip erase sets the error flag.
// - 264-byte mode: 58, five dummy, ten page, nine byte bits.
// - 256-byte mode: 58, six dummy, ten page, eight byte bits.
// - one to a page of data bytes enter buffer, pointer wraps.
// - select rising after data starts rmw, only received bytes reprogrammed.
// - select rising off a byte boundary aborts rmw, nothing programmed.
// - busy during rmw; failing byte sets the error flag.
// - rmw opcode and address with no data performs page rewrite.
// - software protection is cleared at every power-up.
// - unconnected write-protect pin reads deasserted via pull-up.
// - bytes 3d 2a 7f a9 then select rising enable protection.
// - bytes 3d 2a 7f 9a then select rising disable protection.
// - with protection on, program and erase of selected sectors refused.
// - status reports protection enabled, by software or by pin.
// - protection byte of all ones selects its sector for protection.
// - disable sequence ignored while write-protect pin asserted.
`timescale 1ns/10ps
`default_nettype none
module fec_top
  import fec_pkg::*;
#(
  parameter int ERASE_CYCLES = fec_pkg::ERASE_CYC,
  parameter int PROG_CYCLES  = fec_pkg::PROG_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  cs_n,
  input  wire logic                  sck,
  input  wire logic                  si,
  input  wire logic                  wp_n,
  input  wire logic                  page_264,
  input  wire logic [NUM_SECT*8-1:0] prot_bytes,
  input  wire logic                  lock_any,
  input  wire logic                  array_fail,
  output fec_pkg::fec_status_t       status,
  output fec_pkg::fec_job_t          job,
  output logic                       job_start,
  output logic                       buf_we,
  output logic [8:0]                 buf_addr,
  output logic [7:0]                 buf_data
);
  import fec_pkg::*;

  typedef enum logic [4:0] {
    ST_OP    = 5'b00001,
    ST_SEQ   = 5'b00010,
    ST_ADDR  = 5'b00100,
    ST_DATA  = 5'b01000,
    ST_SKIP  = 5'b10000
  } fec_state_t;

  logic cs_s, cs_rise, cs_fall, sck_rise, si_s;
  // wp_n is assumed pulled high outside when left open
  logic wp_s;

  fec_sync #(.RST_VAL(1'b1)) u_cs (.clk_sys(clk_sys), .nrst(nrst), .din(cs_n),
    .dout(cs_s), .rise(cs_rise), .fall(cs_fall));
  fec_sync #(.RST_VAL(1'b0)) u_sck (.clk_sys(clk_sys), .nrst(nrst), .din(sck),
    .dout(), .rise(sck_rise), .fall());
  fec_sync #(.RST_VAL(1'b0)) u_si (.clk_sys(clk_sys), .nrst(nrst), .din(si),
    .dout(si_s), .rise(), .fall());
  fec_sync #(.RST_VAL(1'b1)) u_wp (.clk_sys(clk_sys), .nrst(nrst), .din(wp_n),
    .dout(wp_s), .rise(), .fall());

  // si is two stages behind like sck, so sampling stays aligned
  fec_state_t  state_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_reg;
  logic [1:0]  idx_reg;
  logic [1:0]  seq_reg;   // 1 chip erase, 2 protect family
  logic [7:0]  last_op_reg;
  logic [23:0] addr_reg;
  logic [8:0]  ptr_reg;
  logic [8:0]  cnt_reg;
  logic        have_data_reg;
  logic [7:0]  byte_next;
  logic        byte_done;

  assign byte_next = {shift_reg[6:0], si_s};
  assign byte_done = sck_rise && !cs_s && bit_reg == 3'h7;

  logic [8:0] page_size;
  assign page_size = page_264 ? 9'h108 : 9'h100;

  logic busy_reg;
  logic [31:0] tmr_reg;
  logic sw_prot_reg;
  logic err_reg;
  logic hw_prot_reg;

  // byte assembly
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= 8'h00;
      bit_reg   <= 3'h0;
    end else if (cs_s || cs_fall) begin
      bit_reg <= 3'h0;
    end else if (sck_rise) begin
      shift_reg <= byte_next;
      bit_reg   <= bit_reg + 3'h1;
    end
  end

  logic seq_ok;
  always_comb begin
    seq_ok = 1'b0;
    case (idx_reg)
      2'h1: seq_ok = seq_reg == 2'h1 ? byte_next == OP_ERASE_B1 : byte_next == OP_PROT_B1;
      2'h2: seq_ok = seq_reg == 2'h1 ? byte_next == OP_ERASE_B2 : byte_next == OP_PROT_B2;
      2'h3: seq_ok = seq_reg == 2'h1 ? byte_next == OP_ERASE_B3 :
                     (byte_next == OP_PROT_EN || byte_next == OP_PROT_DIS);
      default: seq_ok = 1'b0;
    endcase
  end

  // command decode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_OP;
      idx_reg       <= 2'h0;
      seq_reg       <= 2'h0;
      last_op_reg   <= 8'h00;
      addr_reg      <= 24'h000000;
      ptr_reg       <= 9'h000;
      cnt_reg       <= 9'h000;
      have_data_reg <= 1'b0;
    end else if (cs_s) begin
      state_reg     <= ST_OP;
      idx_reg       <= 2'h0;
      seq_reg       <= 2'h0;
      have_data_reg <= 1'b0;
    end else if (byte_done && !busy_reg) begin
      case (state_reg)
        ST_OP: begin
          if (byte_next == OP_ERASE_B0) begin
            state_reg <= ST_SEQ;
            seq_reg   <= 2'h1;
            idx_reg   <= 2'h1;
          end else if (byte_next == OP_PROT_B0) begin
            state_reg <= ST_SEQ;
            seq_reg   <= 2'h2;
            idx_reg   <= 2'h1;
          end else if (byte_next == OP_RMW) begin
            state_reg <= ST_ADDR;
            idx_reg   <= 2'h0;
          end else begin
            state_reg <= ST_SKIP;
          end
        end
        ST_SEQ: begin
          if (seq_ok) begin
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == 2'h3) begin
              last_op_reg <= byte_next;
              state_reg   <= ST_SKIP; // trailing bytes dropped
            end
          end else begin
            seq_reg   <= 2'h0;
            state_reg <= ST_SKIP;
          end
        end
        ST_ADDR: begin
          addr_reg <= {addr_reg[15:0], byte_next};
          idx_reg  <= idx_reg + 2'h1;
          if (idx_reg == 2'h2) begin
            state_reg <= ST_DATA;
            cnt_reg   <= 9'h000;
            // start byte: nine bits in 264 mode, eight in 256 mode
            ptr_reg   <= page_264 ? {addr_reg[0], byte_next} : {1'b0, byte_next};
          end
        end
        ST_DATA: begin
          have_data_reg <= 1'b1;
          if (cnt_reg != page_size)
            cnt_reg <= cnt_reg + 9'h001;
          ptr_reg <= (ptr_reg + 9'h001 >= page_size) ? 9'h000 : ptr_reg + 9'h001;
        end
        default: state_reg <= ST_SKIP;
      endcase
    end
  end

  // buffer write port
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      buf_we   <= 1'b0;
      buf_addr <= 9'h000;
      buf_data <= 8'h00;
    end else begin
      buf_we <= byte_done && !busy_reg && state_reg == ST_DATA;
      if (byte_done) begin
        buf_addr <= ptr_reg;
        buf_data <= byte_next;
      end
    end
  end

  // commands only complete on select rising with a whole byte count
  logic cmd_end, erase_go, prot_on_go, prot_off_go, rmw_go;
  assign cmd_end     = cs_rise && !busy_reg && bit_reg == 3'h0;
  assign erase_go    = cmd_end && seq_reg == 2'h1 && idx_reg == 2'h0 &&
                       last_op_reg == OP_ERASE_B3 && state_reg == ST_SKIP;
  assign prot_on_go  = cmd_end && seq_reg == 2'h2 && idx_reg == 2'h0 &&
                       last_op_reg == OP_PROT_EN && state_reg == ST_SKIP;
  assign prot_off_go = cmd_end && seq_reg == 2'h2 && idx_reg == 2'h0 &&
                       last_op_reg == OP_PROT_DIS && state_reg == ST_SKIP && wp_s;
  assign rmw_go      = cmd_end && state_reg == ST_DATA;

  // page of the pending rmw, in either address layout
  logic [PAGE_BITS-1:0] rmw_page;
  assign rmw_page = page_264 ? addr_reg[18:9] : addr_reg[17:8];
  logic [2:0] rmw_sect;
  assign rmw_sect = rmw_page[9:7];
  logic prot_active;
  assign prot_active = sw_prot_reg || hw_prot_reg;
  logic page_locked;
  assign page_locked = prot_active &&
                       prot_bytes[rmw_sect*8 +: 8] == SECT_PROT_VAL;

  // per-sector skip map handed to the sequencer with a chip erase
  logic [NUM_SECT-1:0] skip_mask;
  for (genvar k = 0; k < NUM_SECT; k++) begin : g_skip
    assign skip_mask[k] = prot_active && prot_bytes[k*8 +: 8] == SECT_PROT_VAL;
  end

  // self-timed operation sequencing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg  <= 1'b0;
      tmr_reg   <= 32'h0;
      job_start <= 1'b0;
      job       <= '0;
    end else begin
      job_start <= 1'b0;
      if (busy_reg) begin
        if (tmr_reg != 32'h0)
          tmr_reg <= tmr_reg - 32'h1;
        else
          busy_reg <= 1'b0;
      end else if (erase_go) begin
        busy_reg  <= 1'b1;
        tmr_reg   <= 32'(ERASE_CYCLES - 1);
        job_start <= 1'b1;
        // start carries the sectors to leave alone, count bit 0 the lockdown flag
        job       <= '{op: FEC_OP_ERASE, page: '0,
                       start: {1'b0, skip_mask}, count: {8'h00, lock_any}};
      end else if (rmw_go && !page_locked) begin
        busy_reg  <= 1'b1;
        tmr_reg   <= 32'(PROG_CYCLES - 1);
        job_start <= 1'b1;
        job       <= '{op: have_data_reg ? FEC_OP_RMW : FEC_OP_REWRITE,
                       page: rmw_page,
                       start: page_264 ? addr_reg[8:0] : {1'b0, addr_reg[7:0]},
                       count: cnt_reg};
      end
    end
  end

  // error flag: result of the last self-timed operation
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      err_reg <= 1'b0;
    else if (busy_reg && array_fail)
      err_reg <= 1'b1; // set wins, so a failure in the start cycle is not lost
    else if (job_start)
      err_reg <= 1'b0;
  end

  // software protection, cleared by reset at power-up
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      sw_prot_reg <= 1'b0;
    else if (prot_on_go)
      sw_prot_reg <= 1'b1;
    else if (prot_off_go)
      sw_prot_reg <= 1'b0;
  end

  // pin protection follows wp only while idle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      hw_prot_reg <= 1'b0;
    else if (!busy_reg)
      hw_prot_reg <= !wp_s;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      status <= '{ready: 1'b1, prog_error: 1'b0, prot_enabled: 1'b0};
    else
      status <= '{ready: !busy_reg, prog_error: err_reg, prot_enabled: prot_active};
  end

  property busy_hold_p;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(busy_reg) |-> busy_reg[*8];
  endproperty
  busy_hold_a: assert property (busy_hold_p) else $error("busy dropped early");

  // a started job: busy raised together with the one-cycle start pulse
  sequence job_go_s;
    busy_reg && job_start;
  endsequence

  erase_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    erase_go |=> job_go_s ##0 job.op == FEC_OP_ERASE)
    else $error("chip erase did not start");

  erase_skip_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    erase_go |=> job.start[NUM_SECT-1:0] == $past(skip_mask))
    else $error("erase skip map wrong");

  rewrite_op_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rmw_go && !page_locked && !have_data_reg |=> job_go_s ##0 job.op == FEC_OP_REWRITE)
    else $error("page rewrite not chosen");

  prot_on_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    prot_on_go |=> sw_prot_reg) else $error("protection not enabled");

  prot_off_wp_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sw_prot_reg && !wp_s |=> sw_prot_reg) else $error("disable taken under wp");

  partial_abort_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cs_rise && bit_reg != 3'h0 && !busy_reg |=> !job_start)
    else $error("partial byte started job");

  hw_defer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    busy_reg && $past(busy_reg) |-> $stable(hw_prot_reg))
    else $error("hw protect changed in erase");

  err_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    busy_reg && array_fail |=> err_reg) else $error("error flag missed");

  locked_refuse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rmw_go && page_locked && !busy_reg |=> !busy_reg)
    else $error("protected page written");

  status_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ##1 status.ready == !$past(busy_reg)) else $error("status ready wrong");
endmodule
`default_nettype wire

// >>> verification/fec_host.sv
// host serial controller model driving select, clock and data
`timescale 1ns/10ps
`default_nettype none
module fec_host (
  input  wire logic clk_sys,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b1;
  end
  // a half period of the 320 ns link clock
  task automatic half;
    repeat (4) @(posedge clk_sys);
  endtask
  // clock stays low between frames; the gap lets the select rise be seen
  task automatic frame(input logic [63:0] d, input int nbits);
    repeat (3) half();
    cs_n <= 1'b0;
    half();
    for (int i = 0; i < nbits; i++) begin
      si <= d[63-i];
      half();
      sck <= 1'b1;
      half();
      sck <= 1'b0;
    end
    half();
    cs_n <= 1'b1;
    si   <= ~si;
  endtask
endmodule
`default_nettype wire

// >>> verification/fec_top_tb.sv
// self-checking bench for the flash command interpreter
`timescale 1ns/10ps
`default_nettype none
module fec_top_tb;
  import fec_pkg::*;
  typedef struct {fec_job_t j; int lvl;} fec_note_t;
  logic                  clk_sys;
  logic                  nrst;
  logic                  cs_n;
  logic                  sck;
  logic                  si;
  logic                  wp_n;
  logic                  page_264;
  logic                  lock_any;
  logic                  array_fail;
  logic [NUM_SECT*8-1:0] prot_bytes;
  fec_status_t           status;
  fec_job_t              job;
  logic                  job_start;
  logic                  buf_we;
  logic [8:0]            buf_addr;
  logic [7:0]            buf_data;
  int                    failures = 0;
  int                    check_count = 0;
  fec_note_t             jobq[$];
  logic [16:0]           bufq[$];

  fec_host u_fec_host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si));
  fec_top #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) u_fec_top (
    .clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .page_264(page_264), .prot_bytes(prot_bytes), .lock_any(lock_any),
    .array_fail(array_fail), .status(status), .job(job), .job_start(job_start),
    .buf_we(buf_we), .buf_addr(buf_addr), .buf_data(buf_data));

  always #20 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // level 0 checks the operation, 1 adds the page, 2 adds start and count
  task automatic note(input fec_op_t op, input logic [9:0] pg, input logic [8:0] st,
                      input logic [8:0] cnt, input int lvl);
    fec_note_t nt;
    nt.j  = '{op, pg, st, cnt};
    nt.lvl = lvl;
    jobq.push_back(nt);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (status.ready !== 1'b1 && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    chk(status.ready, 1, "stuck busy");
  endtask

  task automatic go(input logic [63:0] d, input int nb, input logic busy);
    u_fec_host.frame(d, nb);
    repeat (8) @(posedge clk_sys);
    if (busy) chk(status.ready, 0, "busy");
    wait_idle();
  endtask

  task automatic rmw(input logic [9:0] pg, input logic [8:0] st, input int n,
                     input int extra, input logic ok);
    logic [63:0] d;
    logic [8:0]  a;
    logic [7:0]  b;
    d = {OP_RMW, page_264 ? {5'h0, pg, st} : {6'h0, pg, st[7:0]}, 32'h0};
    a = page_264 ? st : {1'b0, st[7:0]};
    if (ok) note(n > 0 ? FEC_OP_RMW : FEC_OP_REWRITE, pg, a, 9'(n), 2);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      d[31-8*i -: 8] = b;
      bufq.push_back({a, b});
      a = (a == (page_264 ? 9'd263 : 9'd255)) ? 9'h0 : a + 9'h1;
    end
    go(d, 32 + 8 * n + extra, ok);
  endtask

  task automatic prot(input logic [7:0] last);
    u_fec_host.frame({OP_PROT_B0, OP_PROT_B1, OP_PROT_B2, last, 32'h0}, 32);
    repeat (8) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    fec_note_t n;
    if (job_start === 1'b1) begin
      if (jobq.size() == 0) chk(1, 0, "unexpected job");
      else begin
        n = jobq.pop_front();
        chk(job.op, n.j.op, "job op");
        if (n.lvl > 0) chk(job.page, n.j.page, "job page");
        if (n.lvl > 1) chk({job.start, job.count}, {n.j.start, n.j.count}, "job span");
      end
    end
    if (buf_we === 1'b1) begin
      if (bufq.size() == 0) chk(1, 0, "unexpected buffer write");
      else chk({buf_addr, buf_data}, bufq.pop_front(), "buffer write");
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end

  initial begin
    clk_sys    = 1'b0;
    nrst       = 1'b0;
    wp_n       = 1'b1;
    page_264   = 1'b0;
    lock_any   = 1'b0;
    array_fail = 1'b0;
    prot_bytes = 64'h0000_ff00_0000_0000;
    void'($urandom(70));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({status.ready, status.prog_error, status.prot_enabled}, 3'b100, "reset");
    // chip erase with a trailing byte, a failing array and the pin asserted mid-way
    array_fail <= 1'b1;
    lock_any   <= 1'b1;
    // no protection active yet, so no sector skipped; lockdown flag travels in count bit 0
    note(FEC_OP_ERASE, 10'h0, 9'h000, 9'h001, 2);
    u_fec_host.frame({OP_ERASE_B0, OP_ERASE_B1, OP_ERASE_B2, OP_ERASE_B3, 8'h55, 24'h0}, 40);
    repeat (8) @(posedge clk_sys);
    chk(status.ready, 0, "erase busy");
    wp_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(status.prot_enabled, 0, "pin deferred");
    wait_idle();
    repeat (8) @(posedge clk_sys);
    chk(status.prog_error, 1, "erase error");
    chk(status.prot_enabled, 1, "pin protect");
    wp_n       <= 1'b1;
    array_fail <= 1'b0;
    lock_any   <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(status.prot_enabled, 0, "pin release");
    go({OP_ERASE_B0, OP_ERASE_B1, OP_ERASE_B2, 8'h9b, 32'h0}, 32, 1'b0);
    go({OP_ERASE_B0, OP_ERASE_B1, OP_ERASE_B2, 40'h0}, 24, 1'b0);
    prot(OP_PROT_EN);
    chk(status.prot_enabled, 1, "soft enable");
    // sector 5 is the only one whose protection byte is all ones
    note(FEC_OP_ERASE, 10'h0, {1'b0, 8'h20}, 9'h000, 2);
    go({OP_ERASE_B0, OP_ERASE_B1, OP_ERASE_B2, OP_ERASE_B3, 32'h0}, 32, 1'b1);
    rmw({3'd5, 7'($urandom)}, 9'h0, 0, 0, 1'b0);
    rmw({3'd2, 7'($urandom)}, 9'h3, 1, 0, 1'b1);
    wp_n <= 1'b0;
    prot(OP_PROT_DIS);
    wp_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(status.prot_enabled, 1, "disable ignored");
    prot(OP_PROT_DIS);
    chk(status.prot_enabled, 0, "soft disable");
    for (int m = 0; m < 2; m++) begin
      page_264 <= m[0];
      @(posedge clk_sys);
      rmw({3'd2, 7'($urandom)}, m ? 9'd262 : 9'd254, 3, 0, 1'b1);
      rmw({3'd6, 7'($urandom)}, 9'($urandom), 0, 0, 1'b1);
      rmw({3'd1, 7'($urandom)}, 9'h0, 0, 4, 1'b0);
    end
    repeat (20) @(posedge clk_sys);
    chk(jobq.size() + bufq.size(), 0, "results missing");
    end_of_test();
  end
endmodule
`default_nettype wire
